/* File: logic/hbi_host_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hbi_defs.svh"

module hbi_host_if (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  interface_select_low,
   input  wire logic                  interface_select_high,
   input  wire logic                  ale,
   input  wire logic                  rd_n,
   input  wire logic                  wr_n,
   input  wire logic                  address_strobe,
   input  wire logic                  enable_strobe,
   input  wire logic                  rnw,
   input  wire logic                  cs_n,
   input  wire logic [15:0]           ad_i,
   output logic [15:0]                ad_o,
   output logic                       ad_oe,
   output logic                       ready,
   output logic                       data_ack_n,
   input  wire logic [7:0]            p1_i,
   output logic [7:0]                 p1_o,
   output logic [7:0]                 p1_oe,
   input  wire logic [7:0]            p2_i,
   output logic [7:0]                 p2_o,
   output logic [7:0]                 p2_oe,
   output hbi_pkg::hbi_mode_e         host_mode,
   input  wire logic                  can_req,
   input  wire logic                  can_we,
   input  wire logic [7:0]            can_addr,
   input  wire logic [7:0]            can_wdata,
   output logic                       can_gnt,
   output logic [7:0]                 can_rdata,
   output hbi_pkg::hbi_mem_cmd_s      mem_cmd,
   input  wire logic [7:0]            mem_rdata
);
   import hbi_pkg::*;

   function automatic hbi_mode_e decode_mode(input logic [1:0] sel, input logic rdn,
                                             input logic wrn);
      hbi_mode_e m;
      m = HBI_MODE_NM8;
      case (sel)
         `HBI_SEL_LS8:  m = (!rdn && !wrn) ? HBI_MODE_SERIAL : HBI_MODE_LS8;
         `HBI_SEL_LS16: m = HBI_MODE_LS16;
         `HBI_SEL_AS8:  m = HBI_MODE_AS8;
         default:       m = HBI_MODE_NM8;
      endcase
      return m;
   endfunction

   hbi_mode_e    mode_q;
   hbi_mode_e    mode_d;
   hbi_mode_e    mode_dec;
   hbi_state_e   state_q;
   hbi_state_e   state_d;
   logic [7:0]   addr_q;
   logic [7:0]   addr_d;
   logic         req_we_q;
   logic         req_we_d;
   logic [7:0]   req_addr_q;
   logic [7:0]   req_addr_d;
   logic [15:0]  req_wdata_q;
   logic [15:0]  req_wdata_d;
   logic         byte_q;
   logic         byte_d;
   logic [15:0]  rdata_q;
   logic [15:0]  rdata_d;
   logic [15:0]  frh_q;
   logic [15:0]  frh_d;
   hbi_mem_cmd_s mem_cmd_q;
   hbi_mem_cmd_s mem_cmd_d;
   logic         last_host_q;
   logic         last_host_d;
   logic         strobe_rd;
   logic         strobe_wr;
   logic         is_wide;
   logic [7:0]   cur_addr;
   logic [15:0]  cur_wdata;
   logic         local_hit;
   logic [15:0]  local_rdata;
   logic         port_hit;
   logic [7:0]   port_rdata;
   logic         port_wr;
   logic [7:0]   port1_o;
   logic [7:0]   port1_oe;
   logic         host_req;
   logic         host_win;
   logic         can_win;
   logic [7:0]   host_addr;
   logic [7:0]   host_wdata;
   logic         nm_drive;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus mode and strobe decode.
   always_comb begin
      mode_dec = decode_mode({interface_select_high, interface_select_low}, rd_n, wr_n);
      mode_d   = !nrst ? mode_dec : mode_q;
      addr_d   = addr_q;
      strobe_rd = 1'b0;
      strobe_wr = 1'b0;
      case (mode_q)
         HBI_MODE_LS8, HBI_MODE_LS16: begin
            if (ale) begin
               addr_d = ad_i[7:0];
            end
            strobe_rd = !rd_n;
            strobe_wr = !wr_n && rd_n;
         end
         HBI_MODE_AS8: begin
            if (address_strobe) begin
               addr_d = ad_i[7:0];
            end
            strobe_rd = enable_strobe && rnw;
            strobe_wr = enable_strobe && !rnw;
         end
         HBI_MODE_NM8: begin
            strobe_rd = !cs_n && enable_strobe && rnw;
            strobe_wr = !cs_n && enable_strobe && !rnw;
         end
         // The serial protocol lives elsewhere; the parallel path stays quiet.
         default: strobe_rd = 1'b0;
      endcase
      is_wide = (mode_q == HBI_MODE_LS16);
      // Non-multiplexed mode: address on bus, data on port one.
      cur_addr  = (mode_q == HBI_MODE_NM8) ? ad_i[7:0] : addr_q;
      cur_wdata = is_wide ? ad_i :
                  (mode_q == HBI_MODE_NM8) ? {`HBI_BYTE_ZERO, p1_i} : {`HBI_BYTE_ZERO, ad_i[7:0]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host access sequencer.
   always_comb begin
      local_hit = port_hit || cur_addr == `HBI_ADDR_FRH_LO || cur_addr == `HBI_ADDR_FRH_HI;
      if (port_hit) begin
         local_rdata = {`HBI_BYTE_ZERO, port_rdata};
      end else if (cur_addr == `HBI_ADDR_FRH_HI) begin
         local_rdata = {`HBI_BYTE_ZERO, frh_q[15:8]};
      end else begin
         local_rdata = is_wide ? frh_q : {`HBI_BYTE_ZERO, frh_q[7:0]};
      end
      state_d     = state_q;
      req_we_d    = req_we_q;
      req_addr_d  = req_addr_q;
      req_wdata_d = req_wdata_q;
      byte_d      = byte_q;
      rdata_d     = rdata_q;
      frh_d       = frh_q;
      host_req    = 1'b0;
      port_wr     = 1'b0;
      case (state_q)
         HBI_ST_IDLE: begin
            if (strobe_rd || strobe_wr) begin
               req_we_d    = strobe_wr;
               req_addr_d  = cur_addr;
               req_wdata_d = cur_wdata;
               byte_d      = 1'b0;
               if (local_hit) begin
                  port_wr = strobe_wr && port_hit;
                  rdata_d = local_rdata;
                  state_d = HBI_ST_HOLD;
               end else begin
                  state_d = HBI_ST_REQ;
               end
            end
         end
         // Wait until the shared bus is ours.
         HBI_ST_REQ: begin
            host_req = 1'b1;
            if (host_win) begin
               state_d = HBI_ST_ACC;
            end
         end
         HBI_ST_ACC: state_d = HBI_ST_CAP;
         HBI_ST_CAP: begin
            if (!req_we_q) begin
               // Every host memory read refreshes holding register.
               if (byte_q) begin
                  rdata_d[15:8] = mem_rdata;
                  frh_d[15:8]   = mem_rdata;
               end else begin
                  rdata_d = {`HBI_BYTE_ZERO, mem_rdata};
                  frh_d   = {`HBI_BYTE_ZERO, mem_rdata};
               end
            end
            // A wide access is two byte accesses, low byte first.
            if (is_wide && !byte_q) begin
               byte_d  = 1'b1;
               state_d = HBI_ST_REQ;
            end else begin
               state_d = HBI_ST_HOLD;
            end
         end
         HBI_ST_HOLD: begin
            if (!(strobe_rd || strobe_wr)) begin
               state_d = HBI_ST_IDLE;
            end
         end
         default: state_d = HBI_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Internal memory bus arbiter, round robin so neither side starves.
   always_comb begin
      host_addr   = byte_q ? 8'(req_addr_q + `HBI_ADDR_STEP) : req_addr_q;
      host_wdata  = byte_q ? req_wdata_q[15:8] : req_wdata_q[7:0];
      host_win    = host_req && (!can_req || !last_host_q);
      can_win     = can_req && !host_win;
      mem_cmd_d   = '0;
      last_host_d = last_host_q;
      if (host_win) begin
         mem_cmd_d.en    = 1'b1;
         mem_cmd_d.we    = req_we_q;
         mem_cmd_d.addr  = host_addr;
         mem_cmd_d.wdata = host_wdata;
         last_host_d     = 1'b1;
      end else if (can_win) begin
         mem_cmd_d.en    = 1'b1;
         mem_cmd_d.we    = can_we;
         mem_cmd_d.addr  = can_addr;
         mem_cmd_d.wdata = can_wdata;
         last_host_d     = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      mode_q <= mode_d;
      if (!nrst) begin
         state_q     <= HBI_ST_IDLE;
         addr_q      <= `HBI_BYTE_ZERO;
         req_we_q    <= 1'b0;
         req_addr_q  <= `HBI_BYTE_ZERO;
         req_wdata_q <= `HBI_FRH_RST;
         byte_q      <= 1'b0;
         rdata_q     <= `HBI_FRH_RST;
         frh_q       <= `HBI_FRH_RST;
         mem_cmd_q   <= '0;
         last_host_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         addr_q      <= addr_d;
         req_we_q    <= req_we_d;
         req_addr_q  <= req_addr_d;
         req_wdata_q <= req_wdata_d;
         byte_q      <= byte_d;
         rdata_q     <= rdata_d;
         frh_q       <= frh_d;
         mem_cmd_q   <= mem_cmd_d;
         last_host_q <= last_host_d;
      end
   end

   hbi_port_pair u_ports (
      .clk   (clk),
      .nrst  (nrst),
      .wr_en (port_wr),
      .addr  (cur_addr),
      .wdata (cur_wdata[7:0]),
      .p1_i  (p1_i),
      .p2_i  (p2_i),
      .hit   (port_hit),
      .rdata (port_rdata),
      .p1_o  (port1_o),
      .p1_oe (port1_oe),
      .p2_o  (p2_o),
      .p2_oe (p2_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Pin outputs. Port one is the data bus in non-multiplexed mode.
   assign nm_drive   = mode_q == HBI_MODE_NM8 && state_q == HBI_ST_HOLD && strobe_rd;
   assign p1_o       = nm_drive ? rdata_q[7:0] : port1_o;
   assign p1_oe      = nm_drive ? '1 : (mode_q == HBI_MODE_NM8) ? '0 : port1_oe;
   assign ad_o       = rdata_q;
   assign ad_oe      = state_q == HBI_ST_HOLD && strobe_rd && mode_q != HBI_MODE_NM8;
   assign ready      = state_q == HBI_ST_HOLD || !(strobe_rd || strobe_wr);
   assign data_ack_n = !(mode_q == HBI_MODE_NM8 && state_q == HBI_ST_HOLD
                         && (strobe_rd || strobe_wr));
   assign host_mode  = mode_q;
   assign can_gnt    = can_win;
   assign can_rdata  = mem_rdata;
   assign mem_cmd    = mem_cmd_q;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_mode_kept: assert property (##1 nrst |-> $stable(mode_q))
      else $error("interface mode changed outside reset");
   chk_mode_decode: assert property ($rose(nrst) && $past({interface_select_high, interface_select_low}) == `HBI_SEL_NM8 |-> mode_q == HBI_MODE_NM8)
      else $error("select code three did not give non-multiplexed mode");
   chk_serial_pick: assert property ($rose(nrst) && $past({interface_select_high, interface_select_low, rd_n, wr_n}) == 4'h0 |-> mode_q == HBI_MODE_SERIAL)
      else $error("both strobes low in reset did not give serial mode");
   chk_ready_wait: assert property (state_q == HBI_ST_IDLE && strobe_rd && !local_hit && mode_q == HBI_MODE_LS8 |-> !ready ##1 (!ready || !strobe_rd) ##1 (!ready || !strobe_rd))
      else $error("ready did not insert wait states");
   chk_nm_port_data: assert property (state_q == HBI_ST_CAP && !req_we_q && mode_q == HBI_MODE_NM8 ##1 strobe_rd |-> p1_oe == 8'hFF && p1_o == $past(mem_rdata))
      else $error("port one does not carry read data");
   chk_ack_done: assert property (mode_q == HBI_MODE_NM8 && state_q == HBI_ST_REQ |-> data_ack_n ##1 data_ack_n)
      else $error("acknowledge before access finished");
   chk_frh_capture: assert property (state_q == HBI_ST_CAP && !req_we_q && !byte_q |=> frh_q[7:0] == $past(mem_rdata))
      else $error("holding register missed read data");
   chk_host_served: assert property (state_q == HBI_ST_REQ |-> ##[0:1] host_win)
      else $error("host starved on internal bus");
   chk_grant_excl: assert property (host_win |-> !can_win ##1 mem_cmd.en)
      else $error("internal bus grant conflict");

   cov_serial: cover property ($rose(nrst) && mode_q == HBI_MODE_SERIAL);
   cov_wide_read: cover property (is_wide && state_q == HBI_ST_CAP && byte_q && !req_we_q);
   cov_host_waits: cover property (host_req && can_win);

endmodule
`default_nettype wire

/* File: logic/hbi_port_pair.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hbi_defs.svh"

module hbi_port_pair (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wr_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] p1_i,
   input  wire logic [7:0] p2_i,
   output logic            hit,
   output logic [7:0]      rdata,
   output logic [7:0]      p1_o,
   output logic [7:0]      p1_oe,
   output logic [7:0]      p2_o,
   output logic [7:0]      p2_oe
);
   import hbi_pkg::*;

   function automatic hbi_port_sel_s port_decode(input logic [7:0] a);
      hbi_port_sel_s s;
      s.hit  = 1'b1;
      s.idx  = 1'b0;
      s.kind = HBI_PR_DIR;
      case (a)
         `HBI_ADDR_P1_DIR: s.kind = HBI_PR_DIR;
         `HBI_ADDR_P2_DIR: begin
            s.idx  = 1'b1;
            s.kind = HBI_PR_DIR;
         end
         `HBI_ADDR_P1_IN: s.kind = HBI_PR_IN;
         `HBI_ADDR_P2_IN: begin
            s.idx  = 1'b1;
            s.kind = HBI_PR_IN;
         end
         `HBI_ADDR_P1_OUT: s.kind = HBI_PR_OUT;
         `HBI_ADDR_P2_OUT: begin
            s.idx  = 1'b1;
            s.kind = HBI_PR_OUT;
         end
         default: s.hit = 1'b0;
      endcase
      return s;
   endfunction

   logic [7:0]    dir_q [0:1];
   logic [7:0]    dir_d [0:1];
   logic [7:0]    out_q [0:1];
   logic [7:0]    out_d [0:1];
   logic [7:0]    lvl_q [0:1];
   logic [7:0]    lvl_d [0:1];
   hbi_port_sel_s sel;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      sel   = port_decode(addr);
      hit   = sel.hit;
      dir_d = dir_q;
      out_d = out_q;
      lvl_d[0] = p1_i;
      lvl_d[1] = p2_i;
      // Writes to the level registers are dropped; they only mirror the pins.
      if (wr_en && sel.hit && sel.kind == HBI_PR_DIR) begin
         dir_d[sel.idx] = wdata;
      end
      if (wr_en && sel.hit && sel.kind == HBI_PR_OUT) begin
         out_d[sel.idx] = wdata;
      end
      case (sel.kind)
         HBI_PR_DIR: rdata = dir_q[sel.idx];
         HBI_PR_IN:  rdata = lvl_q[sel.idx];
         default:    rdata = out_q[sel.idx];
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dir_q[0] <= `HBI_DIR_RST;
         dir_q[1] <= `HBI_DIR_RST;
         lvl_q[0] <= `HBI_IN_RST;
         lvl_q[1] <= `HBI_IN_RST;
         out_q[0] <= `HBI_OUT_RST;
         out_q[1] <= `HBI_OUT_RST;
      end else begin
         dir_q <= dir_d;
         out_q <= out_d;
         lvl_q <= lvl_d;
      end
   end

   assign p1_oe = dir_q[0];
   assign p2_oe = dir_q[1];
   assign p1_o  = out_q[0];
   assign p2_o  = out_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_dir_write_oe: assert property (wr_en && addr == `HBI_ADDR_P2_DIR |=> p2_oe == $past(wdata))
      else $error("port two enable does not follow direction write");
   chk_level_sample: assert property (##1 (hit && addr == `HBI_ADDR_P1_IN) |-> rdata == $past(p1_i))
      else $error("port one level read is not the pin value");
   chk_port_reset: assert property ($rose(nrst) |-> p1_oe == `HBI_DIR_RST && p2_o == `HBI_OUT_RST && lvl_q[1] == `HBI_IN_RST)
      else $error("port registers not at reset values");

endmodule
`default_nettype wire

/* File: shared/hbi_defs.svh */
`ifndef HBI_DEFS_SVH
`define HBI_DEFS_SVH

// Register addresses on the host side.
`define HBI_ADDR_FRH_LO  8'h04
`define HBI_ADDR_FRH_HI  8'h05
`define HBI_ADDR_P1_DIR  8'h9F
`define HBI_ADDR_P2_DIR  8'hAF
`define HBI_ADDR_P1_IN   8'hBF
`define HBI_ADDR_P2_IN   8'hCF
`define HBI_ADDR_P1_OUT  8'hDF
`define HBI_ADDR_P2_OUT  8'hEF

// Reset values.
`define HBI_DIR_RST      8'h00
`define HBI_IN_RST       8'hFF
`define HBI_OUT_RST      8'h00
`define HBI_FRH_RST      16'h0000
`define HBI_BYTE_ZERO    8'h00
`define HBI_ADDR_STEP    8'h01

// Interface select pin codes {high, low}.
`define HBI_SEL_LS8      2'h0
`define HBI_SEL_LS16     2'h1
`define HBI_SEL_AS8      2'h2
`define HBI_SEL_NM8      2'h3

`endif

/* File: shared/hbi_pkg.sv */
package hbi_pkg;

   typedef enum {
      HBI_MODE_LS8,
      HBI_MODE_LS16,
      HBI_MODE_AS8,
      HBI_MODE_NM8,
      HBI_MODE_SERIAL
   } hbi_mode_e;

   typedef enum {
      HBI_ST_IDLE,
      HBI_ST_REQ,
      HBI_ST_ACC,
      HBI_ST_CAP,
      HBI_ST_HOLD
   } hbi_state_e;

   typedef enum logic [1:0] {
      HBI_PR_DIR,
      HBI_PR_IN,
      HBI_PR_OUT
   } hbi_port_reg_e;

   typedef struct packed {
      logic          hit;
      logic          idx;
      hbi_port_reg_e kind;
   } hbi_port_sel_s;

   // One access on the internal memory bus.
   typedef struct packed {
      logic       en;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hbi_mem_cmd_s;

endpackage

/* File: verif/hbi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model (
   input  wire logic        clk,
   input  wire logic        ready,
   input  wire logic        data_ack_n,
   input  wire logic [15:0] ad_o,
   input  wire logic [7:0]  p1_o,
   output logic             ale,
   output logic             rd_n,
   output logic             wr_n,
   output logic             address_strobe,
   output logic             enable_strobe,
   output logic             rnw,
   output logic             cs_n,
   output logic [7:0]       host_d,
   output logic [15:0]      host_ad
);
   initial begin
      ale = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      address_strobe = 1'b0;
      enable_strobe = 1'b0;
      rnw = 1'b1;
      cs_n = 1'b1;
      host_d = 8'h00;
      host_ad = 16'h5a5a;
   end

   task automatic strobes(input logic lvl);
      rd_n <= lvl;
      wr_n <= lvl;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // One latch-strobe access; a released bus is inverted so stale data never looks valid.
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      int n;
      n = 0;
      q = 8'hxx;
      @(posedge clk);
      ale <= 1'b1;
      host_ad <= {8'h00, a};
      @(posedge clk);
      ale <= 1'b0;
      host_ad <= w ? {8'h00, d} : ~host_ad;
      rd_n <= w;
      wr_n <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 20);
      if (n < 20) begin
         q = ad_o[7:0];
      end
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      host_ad <= ~host_ad;
      repeat (2) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Address-strobe access (nm low) or non-multiplexed access (nm high); the latter
   // ends on the acknowledge and moves its data over port one.
   task automatic mot_access(input logic nm, input logic w, input logic [7:0] a,
                             input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      q = 8'hxx;
      @(posedge clk);
      address_strobe <= !nm;
      cs_n <= 1'b0;
      host_ad <= {8'h00, a};
      host_d <= d;
      @(posedge clk);
      address_strobe <= 1'b0;
      if (!nm) begin
         host_ad <= w ? {8'h00, d} : ~host_ad;
      end
      rnw <= !w;
      enable_strobe <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while ((nm ? data_ack_n !== 1'b0 : ready !== 1'b1) && n < 20);
      if (n < 20) begin
         q = w ? d : nm ? p1_o : ad_o[7:0];
      end
      enable_strobe <= 1'b0;
      cs_n <= 1'b1;
      host_ad <= ~host_ad;
      host_d <= ~host_d;
      repeat (2) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* File: verif/host_bus_interface_and_io_ports_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hbi_defs.svh"
module host_bus_interface_and_io_ports_bench;
   import hbi_pkg::*;
   logic         clk, nrst, sel_lo, sel_hi, ale, rd_n, wr_n, ad_oe, ready;
   logic         can_req, can_we, can_gnt;
   logic         as_s, en_s, rnw, cs_n, ack_n;
   logic [15:0]  host_ad, ad_i, ad_o;
   logic [7:0]   p1_i, p1_o, p1_oe, p2_i, p2_o, p2_oe, ext1, ext2;
   logic [7:0]   can_addr, can_wdata, mem_rdata, host_d;
   logic [7:0]   mem [256];
   logic [7:0]   regs [4] = '{`HBI_ADDR_P1_DIR, `HBI_ADDR_P2_DIR, `HBI_ADDR_P1_OUT,
                              `HBI_ADDR_P2_OUT};
   logic [31:0]  seed = 32'hfebe;
   int           ref_mem [256];
   int           fail_count = 0;
   int           n_tests = 0;
   hbi_mode_e    host_mode;
   hbi_mem_cmd_s mem_cmd;

   assign ad_i = ad_oe ? ad_o : host_ad;
   // Port one is the host's data bus in non-multiplexed mode.
   assign p1_i = (p1_oe & p1_o) | (~p1_oe & (host_mode == HBI_MODE_NM8 ? host_d : ext1));
   assign p2_i = (p2_oe & p2_o) | (~p2_oe & ext2);

   hbi_host_if u_dut (.clk(clk), .nrst(nrst), .interface_select_low(sel_lo),
      .interface_select_high(sel_hi), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .address_strobe(as_s), .enable_strobe(en_s), .rnw(rnw), .cs_n(cs_n),
      .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .ready(ready), .data_ack_n(ack_n),
      .p1_i(p1_i), .p1_o(p1_o), .p1_oe(p1_oe), .p2_i(p2_i), .p2_o(p2_o), .p2_oe(p2_oe),
      .host_mode(host_mode), .can_req(can_req), .can_we(can_we), .can_addr(can_addr),
      .can_wdata(can_wdata), .can_gnt(can_gnt), .can_rdata(), .mem_cmd(mem_cmd),
      .mem_rdata(mem_rdata));

   hbi_host_model u_host (.clk(clk), .ready(ready), .data_ack_n(ack_n), .ad_o(ad_o),
      .p1_o(p1_o), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .address_strobe(as_s),
      .enable_strobe(en_s), .rnw(rnw), .cs_n(cs_n), .host_d(host_d), .host_ad(host_ad));

   ////////////////////////////////////////////////////////////////////////////////
   // Registered memory; idle cycles invert the data so a late capture is caught.
   always @(posedge clk) begin
      if (mem_cmd.en && mem_cmd.we) begin
         mem[mem_cmd.addr] <= mem_cmd.wdata;
      end
      mem_rdata <= mem_cmd.en ? mem[mem_cmd.addr] : ~mem_rdata;
   end

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_mode(input hbi_mode_e g, input hbi_mode_e e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic reset_to(input logic [1:0] sel, input logic serial);
      @(posedge clk);
      nrst <= 1'b0;
      sel_hi <= sel[1];
      sel_lo <= sel[0];
      u_host.strobes(~serial);
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      sel_hi <= ~sel[1];
      sel_lo <= ~sel[0];
      u_host.strobes(1'b1);
      repeat (2) @(posedge clk);
   endtask

   task automatic can_write(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      can_req <= 1'b1;
      can_we <= 1'b1;
      can_addr <= a;
      can_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (can_gnt !== 1'b1 && n < 20);
      can_req <= 1'b0;
      chk8(8'(n < 20), 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      logic [7:0] a, d, q, d1, o1, d2, o2, ca, cd;
      nrst = 1'b0;
      sel_lo = 1'b0;
      sel_hi = 1'b0;
      can_req = 1'b0;
      can_we = 1'b0;
      can_addr = 8'h00;
      can_wdata = 8'h00;
      mem_rdata = 8'h00;
      ext1 = 8'h3c;
      ext2 = 8'hc3;
      foreach (mem[k]) mem[k] = 8'h00;
      for (int i = 0; i < 5; i++) begin
         reset_to((i == 4) ? 2'h0 : 2'(i), i == 4);
         chk_mode(host_mode, hbi_mode_e'(i));
      end
      reset_to(`HBI_SEL_LS8, 1'b0);
      $display("test mode select done");
      chk8(p1_oe | p2_oe | p1_o | p2_o, 8'h00);
      foreach (regs[k]) begin
         u_host.access(1'b0, regs[k], 8'h00, q);
         chk8(q, `HBI_OUT_RST);
      end
      u_host.access(1'b0, `HBI_ADDR_P1_IN, 8'h00, q);
      chk8(q, ext1);
      $display("test reset values done");
      repeat (4) begin
         d1 = rnd();
         o1 = rnd();
         d2 = rnd();
         o2 = rnd();
         u_host.access(1'b1, `HBI_ADDR_P1_DIR, d1, q);
         u_host.access(1'b1, `HBI_ADDR_P1_OUT, o1, q);
         u_host.access(1'b1, `HBI_ADDR_P2_DIR, d2, q);
         u_host.access(1'b1, `HBI_ADDR_P2_OUT, o2, q);
         chk8(p1_oe ^ d1 | p2_oe ^ d2, 8'h00);
         chk8(p1_o ^ o1 | p2_o ^ o2, 8'h00);
         ext1 <= rnd();
         ext2 <= rnd();
         u_host.access(1'b0, `HBI_ADDR_P1_IN, 8'h00, q);
         chk8(q, (d1 & o1) | (~d1 & ext1));
         u_host.access(1'b0, `HBI_ADDR_P2_IN, 8'h00, q);
         chk8(q, (d2 & o2) | (~d2 & ext2));
      end
      $display("test ports done");
      repeat (4) begin
         a = {2'b01, 6'(rnd())};
         d = rnd();
         ref_mem[a] = d;
         u_host.access(1'b1, a, d, q);
         chk8(mem[a], 8'(ref_mem[a]));
         u_host.access(1'b0, a, 8'h00, q);
         chk8(q, 8'(ref_mem[a]));
         u_host.access(1'b1, `HBI_ADDR_FRH_LO, ~d, q);
         u_host.access(1'b0, `HBI_ADDR_FRH_LO, 8'h00, q);
         chk8(q, 8'(ref_mem[a]));
         u_host.access(1'b0, `HBI_ADDR_FRH_HI, 8'h00, q);
         chk8(q, 8'h00);
      end
      $display("test memory done");
      // Each pass shifts the CAN request so it meets the host at a different stage.
      for (int k = 0; k < 4; k++) begin
         ca = {3'b001, 5'(rnd())};
         cd = rnd();
         fork
            u_host.access(1'b0, a, 8'h00, q);
            begin
               repeat (k) @(posedge clk);
               can_write(ca, cd);
            end
         join
         ref_mem[ca] = cd;
         chk8(q, 8'(ref_mem[a]));
         repeat (2) @(posedge clk);
         u_host.access(1'b0, ca, 8'h00, q);
         chk8(q, 8'(ref_mem[ca]));
      end
      $display("test arbitration done");
      // Address-strobe mode, then non-multiplexed mode with data on port one.
      for (int m = 0; m < 2; m++) begin
         reset_to(m ? `HBI_SEL_NM8 : `HBI_SEL_AS8, 1'b0);
         a = {2'b01, 6'(rnd())};
         d = rnd();
         ref_mem[a] = d;
         u_host.mot_access(m[0], 1'b1, a, d, q);
         chk8(q, d);
         chk8(mem[a], 8'(ref_mem[a]));
         u_host.mot_access(m[0], 1'b0, a, 8'h00, q);
         chk8(q, 8'(ref_mem[a]));
      end
      $display("test strobe modes done");
      conclude();
   end
endmodule
`default_nettype wire
